// ---- hdl/fspme_ctrl.sv ----
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/100ps
module fspme_ctrl #(
   parameter int unsigned HALT_TMO_CYC = 50000,
   parameter logic [7:0] RETRY_DEFAULT = 8'h08
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [7:0] sw_rdata,
   output logic [15:0] dev_addr,
   output logic [7:0] dev_wdata,
   output logic dev_wr,
   output logic dev_rd,
   input wire logic [7:0] dev_rdata,
   output logic dev_halt,
   input wire logic dev_halt_done,
   output logic gint_disable,
   output logic gint_enable,
   output logic cpu_clk_fast_req
);
   import fspme_pkg::*;

   localparam logic [15:0] HALT_TMO = 16'(HALT_TMO_CYC);

   typedef struct packed {
      fspme_st_t st;
      fspme_op_t op;
      logic [3:0] step;
      logic [15:0] dev_addr;
      logic [7:0] dev_wdata;
      logic dev_wr;
      logic dev_rd;
      logic halt;
      logic gdi;
      logic gei;
      logic fast;
      logic self_mode;
      logic done;
      logic abn;
      logic refused;
      logic exhaust;
      logic timeout;
      logic [7:0] result;
      logic [7:0] retry;
      logic [7:0] retry_max;
      logic cfg_wdt;
      logic [3:0] blk;
      logic [7:0] mask;
      logic [7:0] sw_rdata;
      logic [15:0] tmo;
   } fspme_state_t;

   fspme_state_t s_r;
   fspme_state_t s_nxt;
   fspme_kind_t kind;
   logic [15:0] tab_addr;
   logic [7:0] tab_data;
   logic busy;
   logic ctrl_wr;
   logic clr_req;

   // Step table lookup
   fspme_step_table u_table (
      .op(s_r.op),
      .step(s_r.step),
      .blk(s_r.blk),
      .mask(s_r.mask),
      .wdt_en(s_r.cfg_wdt),
      .kind(kind),
      .addr(tab_addr),
      .data(tab_data)
   );

   // Decode of software strobes
   assign busy = (s_r.st != S_IDLE);
   assign ctrl_wr = sw_wr && (sw_addr == SW_CTRL);
   assign clr_req = ctrl_wr && sw_wdata[CTRL_CLEAR];

   // Next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.dev_wr = 1'b0;
      s_nxt.dev_rd = 1'b0;
      s_nxt.halt = 1'b0;
      s_nxt.gdi = 1'b0;
      s_nxt.gei = 1'b0;
      s_nxt.sw_rdata = RST_BYTE;
      // Sticky flags cleared first so hardware sets below win
      if (clr_req) begin
         s_nxt.done = 1'b0;
         s_nxt.abn = 1'b0;
         s_nxt.refused = 1'b0;
         s_nxt.exhaust = 1'b0;
         s_nxt.timeout = 1'b0;
      end
      // Software register reads
      if (sw_rd) begin
         unique case (sw_addr)
            SW_CFG: s_nxt.sw_rdata = {7'h00, s_r.cfg_wdt};
            SW_BLOCK: s_nxt.sw_rdata = {4'h0, s_r.blk};
            SW_MASK: s_nxt.sw_rdata = s_r.mask;
            SW_STATUS: s_nxt.sw_rdata = {1'b0, s_r.timeout, s_r.exhaust, s_r.refused,
                                          s_r.abn, s_r.done, s_r.self_mode, busy};
            SW_RESULT: s_nxt.sw_rdata = s_r.result;
            SW_RETRY: s_nxt.sw_rdata = s_r.retry_max;
            default: s_nxt.sw_rdata = RST_BYTE;
         endcase
      end
      // Software register writes; setup held while busy
      if (sw_wr && !busy) begin
         unique case (sw_addr)
            SW_CFG: s_nxt.cfg_wdt = sw_wdata[0];
            SW_BLOCK: s_nxt.blk = sw_wdata[3:0];
            SW_MASK: s_nxt.mask = sw_wdata;
            SW_RETRY: s_nxt.retry_max = sw_wdata;
            default: ;
         endcase
      end
      // Operation start
      if (ctrl_wr && (sw_wdata[2:0] != 3'b000)) begin
         if (busy) begin
            s_nxt.refused = 1'b1;
         end else if (sw_wdata[CTRL_ENTER] && !s_r.self_mode) begin
            s_nxt.op = OP_ENTER;
            s_nxt.fast = 1'b1;
         end else if (sw_wdata[CTRL_EXIT] && s_r.self_mode) begin
            s_nxt.op = OP_EXIT;
         end else if (sw_wdata[CTRL_ERASE] && s_r.self_mode) begin
            s_nxt.op = OP_ERASE;
         end else begin
            s_nxt.refused = 1'b1;
         end
         if (!busy && (s_r.self_mode ? (sw_wdata[2:1] != 2'b00) : sw_wdata[CTRL_ENTER])) begin
            s_nxt.st = S_ISSUE;
            s_nxt.step = 4'h0;
            s_nxt.retry = RST_BYTE;
         end
      end
      // Sequencer
      unique case (s_r.st)
         S_IDLE: ;
         S_ISSUE: begin
            unique case (kind)
               K_WR: begin
                  // Register setup writes, one per cycle
                  s_nxt.dev_wr = 1'b1;
                  s_nxt.dev_addr = tab_addr;
                  s_nxt.dev_wdata = tab_data;
                  s_nxt.step = s_r.step + 4'h1;
               end
               K_DI: begin
                  s_nxt.gdi = 1'b1;
                  s_nxt.step = s_r.step + 4'h1;
               end
               K_EI: begin
                  s_nxt.gei = 1'b1;
                  s_nxt.step = s_r.step + 4'h1;
               end
               K_NOP: s_nxt.step = s_r.step + 4'h1;
               K_HALT: begin
                  s_nxt.halt = 1'b1;
                  s_nxt.tmo = RST_TMO;
                  s_nxt.st = S_HALT;
               end
               K_RD: begin
                  s_nxt.dev_rd = 1'b1;
                  s_nxt.dev_addr = DEV_FLASH_STATUS_ADDR;
                  s_nxt.st = S_RD_A;
               end
               K_END: begin
                  s_nxt.done = 1'b1;
                  s_nxt.st = S_IDLE;
               end
               default: s_nxt.st = S_IDLE;
            endcase
         end
         S_HALT: begin
            // Resume after the halt, or give up
            s_nxt.tmo = s_r.tmo + 16'h0001;
            if (dev_halt_done) begin
               s_nxt.step = s_r.step + 4'h1;
               s_nxt.st = S_ISSUE;
            end else if (s_r.tmo == HALT_TMO) begin
               s_nxt.timeout = 1'b1;
               s_nxt.abn = 1'b1;
               s_nxt.done = 1'b1;
               s_nxt.st = S_IDLE;
            end
         end
         S_RD_A: s_nxt.st = S_RD_B;
         S_RD_B: begin
            s_nxt.result = dev_rdata;
            if (s_r.op == OP_ERASE) begin
               // Any set bit of the status byte is abnormal
               s_nxt.abn = (dev_rdata != VAL_ZERO) || s_nxt.abn;
               s_nxt.done = 1'b1;
               s_nxt.st = S_IDLE;
            end else if (dev_rdata[SEQ_ERR_BIT]) begin
               // Repeat from the status clear
               if (s_r.retry < s_r.retry_max) begin
                  s_nxt.retry = s_r.retry + 8'h01;
                  s_nxt.step = (s_r.op == OP_ENTER) ? ENTER_LOOP_STEP : EXIT_LOOP_STEP;
                  s_nxt.st = S_ISSUE;
               end else begin
                  s_nxt.exhaust = 1'b1;
                  s_nxt.abn = 1'b1;
                  s_nxt.done = 1'b1;
                  s_nxt.st = S_IDLE;
               end
            end else begin
               if (s_r.op == OP_ENTER) begin
                  s_nxt.self_mode = 1'b1;
               end else begin
                  s_nxt.self_mode = 1'b0;
                  s_nxt.fast = 1'b0;
               end
               s_nxt.step = s_r.step + 4'h1;
               s_nxt.st = S_ISSUE;
            end
         end
         default: s_nxt.st = S_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_r <= '{st: S_IDLE, op: OP_ENTER, step: 4'h0, dev_addr: RST_ADDR, dev_wdata: RST_BYTE,
                  dev_wr: 1'b0, dev_rd: 1'b0, halt: 1'b0, gdi: 1'b0, gei: 1'b0, fast: 1'b0,
                  self_mode: 1'b0, done: 1'b0, abn: 1'b0, refused: 1'b0, exhaust: 1'b0,
                  timeout: 1'b0, result: RST_BYTE, retry: RST_BYTE, retry_max: RETRY_DEFAULT,
                  cfg_wdt: 1'b0, blk: 4'h0, mask: RST_BYTE, sw_rdata: RST_BYTE, tmo: RST_TMO};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign sw_rdata = s_r.sw_rdata;
   assign dev_addr = s_r.dev_addr;
   assign dev_wdata = s_r.dev_wdata;
   assign dev_wr = s_r.dev_wr;
   assign dev_rd = s_r.dev_rd;
   assign dev_halt = s_r.halt;
   assign gint_disable = s_r.gdi;
   assign gint_enable = s_r.gei;
   assign cpu_clk_fast_req = s_r.fast;

   // Checks
   sequence q_wr(logic [15:0] a, logic [7:0] d);
      dev_wr && (dev_addr == a) && (dev_wdata == d);
   endsequence

   sequence q_self_tail;
      q_wr(DEV_MODE_CTRL_ADDR, VAL_MODE_SELF) ##1 q_wr(DEV_MODE_CTRL_ADDR, VAL_MODE_SELF_INV)
      ##1 q_wr(DEV_MODE_CTRL_ADDR, VAL_MODE_SELF);
   endsequence

   sequence q_norm_tail;
      q_wr(DEV_MODE_CTRL_ADDR, VAL_MODE_NORM) ##1 q_wr(DEV_MODE_CTRL_ADDR, VAL_MODE_NORM_INV)
      ##1 q_wr(DEV_MODE_CTRL_ADDR, VAL_MODE_NORM);
   endsequence

   sequence q_enter_head;
      q_wr(DEV_INT_MASK_ADDR, VAL_MASK_ALL) ##1 q_wr(DEV_FLASH_CMD_ADDR, VAL_ZERO)
      ##1 gint_disable ##1 q_wr(DEV_FLASH_STATUS_ADDR, VAL_ZERO) ##1 q_wr(DEV_PROTECT_KEY_ADDR, VAL_KEY);
   endsequence

   sequence q_erase_setup;
      q_wr(DEV_FLASH_CMD_ADDR, VAL_CMD_ERASE) ##1 q_wr(DEV_APH_ADDR, {4'h0, s_r.blk})
      ##1 q_wr(DEV_APL_ADDR, VAL_ZERO) ##1 q_wr(DEV_CMPH_ADDR, {4'h0, s_r.blk})
      ##1 q_wr(DEV_CMPL_ADDR, VAL_ZERO) ##1 q_wr(DEV_FLASH_STATUS_ADDR, VAL_ZERO);
   endsequence
   property p_enter_seq;
      @(posedge clk) disable iff (!rst_b)
      (dev_wr && (dev_addr == DEV_PROTECT_KEY_ADDR) && (dev_wdata == VAL_KEY) && (s_r.op == OP_ENTER))
      |=> q_self_tail;
   endproperty
   a_enter_seq: assert property (p_enter_seq) else $error("entry key not followed by 01 FE 01");
   property p_exit_seq;
      @(posedge clk) disable iff (!rst_b)
      (dev_wr && (dev_addr == DEV_PROTECT_KEY_ADDR) && (dev_wdata == VAL_KEY) && (s_r.op == OP_EXIT))
      |=> q_norm_tail;
   endproperty
   a_exit_seq: assert property (p_exit_seq) else $error("exit key not followed by 00 FF 00");

   property p_enter_head;
      @(posedge clk) disable iff (!rst_b)
      ($rose(busy) && (s_r.op == OP_ENTER)) |=> q_enter_head;
   endproperty
   a_enter_head: assert property (p_enter_head) else $error("entry preparation out of order");

   property p_nop_halt;
      @(posedge clk) disable iff (!rst_b)
      (dev_wr && (dev_addr == DEV_MODE_CTRL_ADDR) && (dev_wdata == VAL_MODE_SELF) && (s_r.op == OP_ENTER)
       && (s_r.step == 4'h8)) |=> (!dev_wr && !dev_halt) ##1 dev_halt ##1 !dev_rd [*2];
   endproperty
   a_nop_halt: assert property (p_nop_halt) else $error("entry not closed by nop then halt");

   property p_erase_setup;
      @(posedge clk) disable iff (!rst_b)
      ($rose(busy) && (s_r.op == OP_ERASE)) |=> q_erase_setup;
   endproperty
   a_erase_setup: assert property (p_erase_setup) else $error("erase setup writes wrong");

   property p_high_zero;
      @(posedge clk) disable iff (!rst_b)
      (dev_wr && ((dev_addr == DEV_APH_ADDR) || (dev_addr == DEV_CMPH_ADDR))) |-> (dev_wdata[7:4] == 4'h0);
   endproperty
   a_high_zero: assert property (p_high_zero) else $error("high pointer upper bits set");

   property p_erase_refused;
      @(posedge clk) disable iff (!rst_b)
      (ctrl_wr && (sw_wdata[2:0] == 3'b100) && !s_r.self_mode && !busy) |=> (s_r.refused && !busy);
   endproperty
   a_erase_refused: assert property (p_erase_refused) else $error("erase started outside self mode");

   property p_fast_first;
      @(posedge clk) disable iff (!rst_b)
      q_wr(DEV_MODE_CTRL_ADDR, VAL_MODE_SELF) |-> cpu_clk_fast_req;
   endproperty
   a_fast_first: assert property (p_fast_first) else $error("entry without fast clock");
   property p_restore;
      @(posedge clk) disable iff (!rst_b)
      gint_enable |-> (!s_r.self_mode && !cpu_clk_fast_req && $past(dev_wr)
                       && ($past(dev_addr) == DEV_INT_MASK_ADDR) && ($past(dev_wdata) == s_r.mask));
   endproperty
   a_restore: assert property (p_restore) else $error("interrupts enabled before restore");
   property p_wdt;
      @(posedge clk) disable iff (!rst_b)
      (dev_halt && (s_r.op == OP_ERASE) && s_r.cfg_wdt)
      |-> ($past(dev_wr) && ($past(dev_addr) == DEV_WDT_ADDR) && ($past(dev_wdata) == VAL_WDT_RESTART));
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog not restarted before halt");

   property p_result;
      @(posedge clk) disable iff (!rst_b)
      ((s_r.st == S_RD_B) && (s_r.op == OP_ERASE) && !s_r.abn && !clr_req)
      |=> (s_r.done && (s_r.abn == (s_r.result != VAL_ZERO)));
   endproperty
   a_result: assert property (p_result) else $error("erase result misjudged");
endmodule : fspme_ctrl

// ---- hdl/fspme_pkg.sv ----
package fspme_pkg;
   // Device register addresses (16-bit data space)
   localparam logic [15:0] DEV_INT_MASK_ADDR = 16'hFFE4;
   localparam logic [15:0] DEV_FLASH_CMD_ADDR = 16'hFFA0;
   localparam logic [15:0] DEV_FLASH_STATUS_ADDR = 16'hFFA1;
   localparam logic [15:0] DEV_PROTECT_KEY_ADDR = 16'hFFA2;
   localparam logic [15:0] DEV_MODE_CTRL_ADDR = 16'hFFA3;
   localparam logic [15:0] DEV_APL_ADDR = 16'hFFA4;
   localparam logic [15:0] DEV_APH_ADDR = 16'hFFA5;
   localparam logic [15:0] DEV_CMPH_ADDR = 16'hFFA6;
   localparam logic [15:0] DEV_CMPL_ADDR = 16'hFFA7;
   localparam logic [15:0] DEV_WDT_ADDR = 16'hFFD3;
   // Values written to the device
   localparam logic [7:0] VAL_ZERO = 8'h00;
   localparam logic [7:0] VAL_KEY = 8'hA5;
   localparam logic [7:0] VAL_MODE_SELF = 8'h01;
   localparam logic [7:0] VAL_MODE_SELF_INV = 8'hFE;
   localparam logic [7:0] VAL_MODE_NORM = 8'h00;
   localparam logic [7:0] VAL_MODE_NORM_INV = 8'hFF;
   localparam logic [7:0] VAL_CMD_ERASE = 8'h03;
   localparam logic [7:0] VAL_MASK_ALL = 8'hFF;
   localparam logic [7:0] VAL_WDT_RESTART = 8'hAC;
   // Device status bit positions
   localparam int SEQ_ERR_BIT = 0;
   localparam int VER_ERR_BIT = 1;
   localparam int PROT_ERR_BIT = 2;
   // Software register offsets
   localparam logic [3:0] SW_CTRL = 4'h0;
   localparam logic [3:0] SW_CFG = 4'h1;
   localparam logic [3:0] SW_BLOCK = 4'h2;
   localparam logic [3:0] SW_MASK = 4'h3;
   localparam logic [3:0] SW_STATUS = 4'h4;
   localparam logic [3:0] SW_RESULT = 4'h5;
   localparam logic [3:0] SW_RETRY = 4'h6;
   // Control bits
   localparam int CTRL_ENTER = 0;
   localparam int CTRL_EXIT = 1;
   localparam int CTRL_ERASE = 2;
   localparam int CTRL_CLEAR = 3;
   // Status bits
   localparam int STAT_BUSY = 0;
   localparam int STAT_SELF = 1;
   localparam int STAT_DONE = 2;
   localparam int STAT_ABN = 3;
   localparam int STAT_REFUSED = 4;
   localparam int STAT_EXHAUST = 5;
   localparam int STAT_TIMEOUT = 6;
   // Loop-back steps of the protected sequences
   localparam logic [3:0] ENTER_LOOP_STEP = 4'h3;
   localparam logic [3:0] EXIT_LOOP_STEP = 4'h1;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_ADDR = 16'h0000;
   localparam logic [15:0] RST_TMO = 16'h0000;
   typedef enum logic [1:0] {
      OP_ENTER = 2'b00,
      OP_EXIT = 2'b01,
      OP_ERASE = 2'b10
   } fspme_op_t;
   typedef enum logic [2:0] {
      K_WR = 3'b000,
      K_RD = 3'b001,
      K_HALT = 3'b010,
      K_DI = 3'b011,
      K_EI = 3'b100,
      K_NOP = 3'b101,
      K_END = 3'b110
   } fspme_kind_t;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ISSUE = 3'b001,
      S_RD_A = 3'b010,
      S_RD_B = 3'b011,
      S_HALT = 3'b100
   } fspme_st_t;
endpackage : fspme_pkg

// ---- hdl/fspme_step_table.sv ----
`timescale 1ns/100ps
module fspme_step_table (
   input wire fspme_pkg::fspme_op_t op,
   input wire logic [3:0] step,
   input wire logic [3:0] blk,
   input wire logic [7:0] mask,
   input wire logic wdt_en,
   output fspme_pkg::fspme_kind_t kind,
   output logic [15:0] addr,
   output logic [7:0] data
);
   import fspme_pkg::*;
   // Step list of each operation
   always_comb begin
      kind = K_END;
      addr = RST_ADDR;
      data = VAL_ZERO;
      unique case (op)
         OP_ENTER: begin
            unique case (step)
               4'h0: begin kind = K_WR; addr = DEV_INT_MASK_ADDR; data = VAL_MASK_ALL; end
               4'h1: begin kind = K_WR; addr = DEV_FLASH_CMD_ADDR; data = VAL_ZERO; end
               4'h2: kind = K_DI;
               4'h3: begin kind = K_WR; addr = DEV_FLASH_STATUS_ADDR; data = VAL_ZERO; end
               4'h4: begin kind = K_WR; addr = DEV_PROTECT_KEY_ADDR; data = VAL_KEY; end
               4'h5: begin kind = K_WR; addr = DEV_MODE_CTRL_ADDR; data = VAL_MODE_SELF; end
               4'h6: begin kind = K_WR; addr = DEV_MODE_CTRL_ADDR; data = VAL_MODE_SELF_INV; end
               4'h7: begin kind = K_WR; addr = DEV_MODE_CTRL_ADDR; data = VAL_MODE_SELF; end
               4'h8: kind = K_NOP;
               4'h9: kind = K_HALT;
               4'hA: kind = K_RD;
               default: kind = K_END;
            endcase
         end
         OP_EXIT: begin
            unique case (step)
               4'h0: begin kind = K_WR; addr = DEV_FLASH_CMD_ADDR; data = VAL_ZERO; end
               4'h1: begin kind = K_WR; addr = DEV_FLASH_STATUS_ADDR; data = VAL_ZERO; end
               4'h2: begin kind = K_WR; addr = DEV_PROTECT_KEY_ADDR; data = VAL_KEY; end
               4'h3: begin kind = K_WR; addr = DEV_MODE_CTRL_ADDR; data = VAL_MODE_NORM; end
               4'h4: begin kind = K_WR; addr = DEV_MODE_CTRL_ADDR; data = VAL_MODE_NORM_INV; end
               4'h5: begin kind = K_WR; addr = DEV_MODE_CTRL_ADDR; data = VAL_MODE_NORM; end
               4'h6: kind = K_RD;
               4'h7: begin kind = K_WR; addr = DEV_INT_MASK_ADDR; data = mask; end
               4'h8: kind = K_EI;
               default: kind = K_END;
            endcase
         end
         OP_ERASE: begin
            unique case (step)
               4'h0: begin kind = K_WR; addr = DEV_FLASH_CMD_ADDR; data = VAL_CMD_ERASE; end
               4'h1: begin kind = K_WR; addr = DEV_APH_ADDR; data = {4'h0, blk}; end
               4'h2: begin kind = K_WR; addr = DEV_APL_ADDR; data = VAL_ZERO; end
               4'h3: begin kind = K_WR; addr = DEV_CMPH_ADDR; data = {4'h0, blk}; end
               4'h4: begin kind = K_WR; addr = DEV_CMPL_ADDR; data = VAL_ZERO; end
               4'h5: begin kind = K_WR; addr = DEV_FLASH_STATUS_ADDR; data = VAL_ZERO; end
               4'h6: begin
                  kind = wdt_en ? K_WR : K_NOP;
                  addr = DEV_WDT_ADDR;
                  data = VAL_WDT_RESTART;
               end
               4'h7: kind = K_HALT;
               4'h8: kind = K_RD;
               default: kind = K_END;
            endcase
         end
         default: kind = K_END;
      endcase
   end
endmodule : fspme_step_table

// ---- tb/fspme_dev_model.sv ----
`timescale 1ns/100ps
module fspme_dev_model
   import fspme_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] dev_addr,
   input wire logic [7:0] dev_wdata,
   input wire logic dev_wr,
   input wire logic dev_rd,
   output logic [7:0] dev_rdata,
   input wire logic dev_halt,
   output logic dev_halt_done,
   input wire logic gint_disable,
   input wire logic gint_enable,
   input wire logic [3:0] fail_n,
   input wire logic [7:0] erase_stat,
   input wire logic [7:0] halt_dly
);
   logic [7:0] cmd_r, stat_r, aph_r, apl_r, cmph_r, cmpl_r, mask_r, mv_r, hcnt_r;
   logic self_r, di_r, clr_r, wdt_r;
   logic [1:0] step_r;
   logic [3:0] fails_r;
   int viol;
   // Device registers, protected mode sequence, halt timing
   always @(posedge clk) begin
      dev_halt_done <= 1'b0;
      dev_rdata <= dev_rd ? stat_r : ~dev_rdata;
      if (!rst_b) begin
         {cmd_r, stat_r, aph_r, apl_r, cmph_r, cmpl_r, mask_r, mv_r, hcnt_r} <= '0;
         {self_r, di_r, clr_r, wdt_r, step_r, fails_r} <= '0;
         viol <= 0;
      end else begin
         if (gint_disable) di_r <= 1'b1;
         if (gint_enable) di_r <= 1'b0;
         if (hcnt_r != 8'h00) hcnt_r <= hcnt_r - 8'h01;
         if (dev_halt) hcnt_r <= halt_dly;
         // Command ends: sticky error bits, pointers loaded from the compare registers
         if (hcnt_r == 8'h01) begin
            dev_halt_done <= 1'b1;
            if (self_r && cmd_r == VAL_CMD_ERASE) begin
               stat_r <= stat_r | erase_stat;
               aph_r <= cmph_r;
               apl_r <= cmpl_r;
            end else if (self_r && cmd_r != 8'h00) begin
               stat_r[VER_ERR_BIT] <= 1'b1;
            end
         end
         if (dev_wr) begin
            step_r <= 2'h0;
            case (dev_addr)
               DEV_FLASH_CMD_ADDR: begin
                  cmd_r <= dev_wdata;
                  wdt_r <= 1'b0;
               end
               DEV_FLASH_STATUS_ADDR: begin
                  stat_r <= dev_wdata;
                  clr_r <= (dev_wdata == 8'h00);
               end
               DEV_PROTECT_KEY_ADDR: begin
                  step_r <= {1'b0, dev_wdata == VAL_KEY};
                  if (!clr_r || cmd_r != 8'h00 || (!self_r && (mask_r != VAL_MASK_ALL || !di_r))) viol <= viol + 1;
                  clr_r <= 1'b0;
               end
               DEV_MODE_CTRL_ADDR: begin
                  if (step_r == 2'h1) begin
                     mv_r <= dev_wdata;
                     step_r <= 2'h2;
                  end else if (step_r == 2'h2 && dev_wdata == ~mv_r) begin
                     step_r <= 2'h3;
                  end else if (step_r == 2'h3 && dev_wdata == mv_r && fails_r >= fail_n) begin
                     self_r <= (mv_r == VAL_MODE_SELF);
                  end else begin
                     stat_r[SEQ_ERR_BIT] <= 1'b1;
                     fails_r <= fails_r + 4'h1;
                  end
               end
               DEV_APL_ADDR: apl_r <= dev_wdata;
               DEV_APH_ADDR: aph_r <= dev_wdata;
               DEV_CMPH_ADDR: cmph_r <= dev_wdata;
               DEV_CMPL_ADDR: cmpl_r <= dev_wdata;
               DEV_WDT_ADDR: wdt_r <= (dev_wdata == VAL_WDT_RESTART);
               DEV_INT_MASK_ADDR: mask_r <= dev_wdata;
               default: ;
            endcase
         end
      end
   end
endmodule : fspme_dev_model

// ---- tb/tb_fspme_ctrl.sv ----
`timescale 1ns/100ps
module tb_fspme_ctrl;
   import fspme_pkg::*;
   logic clk, rst_b, sw_wr, sw_rd, dev_wr, dev_rd, dev_halt, dev_halt_done;
   logic gint_disable, gint_enable, cpu_clk_fast_req;
   logic [3:0] sw_addr, fail_n;
   logic [7:0] sw_wdata, sw_rdata, dev_wdata, dev_rdata, erase_stat, halt_dly, d;
   logic [15:0] dev_addr;
   logic [7:0] blk_w [3] = '{8'h07, 8'hF3, 8'h00};
   logic [7:0] errs [3] = '{8'h00, 8'h04, 8'h02};
   int error_cnt, num_checks, cyc;
   fspme_ctrl #(.HALT_TMO_CYC(20), .RETRY_DEFAULT(8'h08)) uut (.clk(clk), .rst_b(rst_b), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .dev_addr(dev_addr),
      .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata), .dev_halt(dev_halt),
      .dev_halt_done(dev_halt_done), .gint_disable(gint_disable), .gint_enable(gint_enable),
      .cpu_clk_fast_req(cpu_clk_fast_req));
   fspme_dev_model dev (.clk(clk), .rst_b(rst_b), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
      .dev_rd(dev_rd), .dev_rdata(dev_rdata), .dev_halt(dev_halt), .dev_halt_done(dev_halt_done),
      .gint_disable(gint_disable), .gint_enable(gint_enable), .fail_n(fail_n), .erase_stat(erase_stat),
      .halt_dly(halt_dly));
   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic conclude;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         conclude();
      end
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= v;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
   endtask : rd
   // Start an operation and poll until it is no longer busy
   task automatic go(input logic [7:0] c);
      wr(SW_CTRL, c);
      rd(SW_STATUS);
      for (int i = 0; i < 300 && d[STAT_BUSY] !== 1'b0; i++) rd(SW_STATUS);
      chk(d & 8'h01, 8'h00);
   endtask : go
   // Main sequence
   initial begin
      {rst_b, sw_addr, sw_wdata, sw_wr, sw_rd, erase_stat, error_cnt, num_checks, cyc} = '0;
      fail_n = 4'h1;
      halt_dly = 8'h03;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      rd(SW_STATUS);
      chk(d, 8'h00);
      rd(SW_RETRY);
      chk(d, 8'h08);
      rd(4'hF);
      chk(d, 8'h00);
      go(8'h04);
      chk(d & 8'h12, 8'h10);
      wr(SW_MASK, 8'h5A);
      go(8'h01);
      chk(d, 8'h16);
      go(8'h08);
      chk(d & 8'h14, 8'h00);
      chk({7'h0, dev.self_r}, 8'h01);
      chk({4'h0, dev.fails_r}, 8'h01);
      chk({7'h0, cpu_clk_fast_req}, 8'h01);
      for (int i = 0; i < 3; i++) begin
         wr(SW_CFG, {7'h0, i[0]});
         wr(SW_BLOCK, blk_w[i]);
         erase_stat <= errs[i];
         go(8'h0C);
         chk(d & 8'h0E, (errs[i] != 8'h00) ? 8'h0E : 8'h06);
         rd(SW_RESULT);
         chk(d, errs[i]);
         chk(dev.cmd_r, VAL_CMD_ERASE);
         chk(dev.cmph_r, blk_w[i] & 8'h0F);
         chk(dev.aph_r, blk_w[i] & 8'h0F);
         chk(dev.apl_r | dev.cmpl_r, 8'h00);
         chk({7'h0, dev.wdt_r}, {7'h0, i[0]});
      end
      rd(SW_STATUS);
      chk(d & 8'h08, 8'h08);
      go(8'h08);
      chk(d & 8'h08, 8'h00);
      erase_stat <= 8'h00;
      halt_dly <= 8'h28;
      go(8'h04);
      chk(d & 8'h4A, 8'h4A);
      halt_dly <= 8'h03;
      repeat (50) @(posedge clk);
      go(8'h02);
      chk(d & 8'h06, 8'h04);
      chk({7'h0, dev.self_r}, 8'h00);
      chk(dev.mask_r, 8'h5A);
      chk({6'h0, dev.di_r, cpu_clk_fast_req}, 8'h00);
      wr(SW_RETRY, 8'h02);
      fail_n <= 4'hF;
      go(8'h09);
      chk(d & 8'h22, 8'h20);
      chk(dev.viol[7:0], 8'h00);
      // Reset after the last run: everything back to idle
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd(SW_STATUS);
      chk(d, 8'h00);
      chk({7'h0, cpu_clk_fast_req}, 8'h00);
      conclude();
   end
endmodule : tb_fspme_ctrl
